// *** clic_host.sv ***
// host processor model: register cycles and acknowledge pulses
`default_nettype none

module clic_host (
   input wire logic mclk,
   output logic [15:0] addr,
   output logic [7:0] wdata,
   output logic wr,
   output logic rd,
   output logic inta
);
   timeunit 1ns;
   timeprecision 1ps;

   // bus idle at time zero
   initial begin
      addr = 16'h0000;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      inta = 1'b0;
   end

   // one write; strobe high for one cycle, then one idle cycle
   task automatic put(input logic [15:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      wdata <= ~d; // released data must not look still valid
      @(posedge mclk);
   endtask

   // one read; the answer lands in the following cycle
   task automatic get(input logic [15:0] a);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(posedge mclk);
   endtask

   // two back-to-back acknowledge pulses
   task automatic ack();
      inta <= 1'b1;
      @(posedge mclk);
      @(posedge mclk);
      inta <= 1'b0;
      @(posedge mclk);
   endtask
endmodule

`default_nettype wire

// *** clic_pkg.sv ***
// shared constants of the cascaded interrupt controller pair
`default_nettype none

package clic_pkg;

   // -------------------------------------------------------------
   // sizes
   // -------------------------------------------------------------
   localparam int unsigned LVL_W = 3;     // bits in a level number
   localparam int unsigned NLVL = 8;      // inputs per controller
   localparam int unsigned NCTL = 2;      // master plus one slave
   localparam int unsigned ADDR_W = 16;   // register port address
   localparam int unsigned DATA_W = 8;    // register port data

   // -------------------------------------------------------------
   // register port offsets
   // -------------------------------------------------------------
   localparam logic [15:0] M_CMD_OFS = 16'h0020;  // master command
   localparam logic [15:0] M_DATA_OFS = 16'h0021; // master data
   localparam logic [15:0] S_CMD_OFS = 16'h00A0;  // slave command
   localparam logic [15:0] S_DATA_OFS = 16'h00A1; // slave data

   // -------------------------------------------------------------
   // command byte field positions
   // -------------------------------------------------------------
   localparam int unsigned INIT1_BIT = 4;  // first init byte marker
   localparam int unsigned OPSEL_BIT = 3;  // 1 selects mode command
   localparam int unsigned POLL_BIT = 2;   // poll request
   localparam int unsigned SMM_HI = 6;     // special mask field
   localparam int unsigned SMM_LO = 5;
   localparam int unsigned RR_HI = 1;      // read register field
   localparam int unsigned RR_LO = 0;
   localparam int unsigned SFNM_BIT = 4;   // special fully nested
   localparam int unsigned VEC_LO = 3;     // vector base low bit

   // end-of-service / rotation codes in bits 7..5
   localparam logic [2:0] EOS_NS = 3'h1;     // nonspecific end
   localparam logic [2:0] EOS_SP = 3'h3;     // specific end
   localparam logic [2:0] EOS_ROT_NS = 3'h5; // rotate, nonspecific
   localparam logic [2:0] SET_PRIO = 3'h6;   // set lowest level
   localparam logic [2:0] EOS_ROT_SP = 3'h7; // rotate, specific

   // -------------------------------------------------------------
   // values after reset and fixed levels
   // -------------------------------------------------------------
   localparam logic [7:0] MASK_RST = 8'hFF;  // all blocked
   localparam logic [2:0] LOW_RST = 3'h7;    // level 7 lowest
   localparam logic [2:0] CASC_LVL = 3'h2;   // slave feeds input 2
   localparam logic [2:0] SPUR_LVL = 3'h7;   // answer when none
   localparam logic [2:0] REDIR_BIT = 3'h1;  // slave input 1

   // initialization progress
   typedef enum logic [1:0] {
      CLIC_READY,
      CLIC_WANT2,
      CLIC_WANT3,
      CLIC_WANT4
   } clic_init_e;

endpackage

`default_nettype wire

// *** clic_res_if.sv ***
// carrier between a controller and its priority resolver
`default_nettype none

interface clic_res_if;
   logic [7:0] req;   // candidate bits
   logic [2:0] low;   // level holding lowest priority
   logic found;       // any candidate set
   logic [2:0] level; // highest priority candidate

   modport res (input req, input low, output found, output level);
   modport user (output req, output low, input found, input level);
endinterface

`default_nettype wire

// *** clic_resolver.sv ***
// rotating priority resolver for eight levels
`default_nettype none

module clic_resolver (
   clic_res_if.res bus
);

   // -------------------------------------------------------------
   // search
   // -------------------------------------------------------------
   // walk from lowest to highest priority so the last hit wins
   always_comb begin
      logic [2:0] idx;
      idx = 3'h0;
      bus.found = 1'b0;
      bus.level = bus.low;
      for (int k = 7; k >= 0; k--) begin
         idx = 3'(bus.low + 3'(k) + 3'h1);
         if (bus.req[idx]) begin
            bus.found = 1'b1;
            bus.level = idx;
         end
      end
   end

endmodule

`default_nettype wire

// *** clic_sync.sv ***
// two-stage synchroniser for request pins
`default_nettype none

module clic_sync #(
   parameter int unsigned WIDTH = 16
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   // first stage, read only by the second
   logic [WIDTH-1:0] meta_q;

   // -------------------------------------------------------------
   // two flops
   // -------------------------------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule

`default_nettype wire

// *** clic_top.sv ***
// cascaded pair of eight-level interrupt controllers
//
// Local design decisions: the strobed register port and the placing of the registers.
`default_nettype none

// What this block does
// - requests are always level sensitive
// - slave's eight inputs feed master input two
// - request and in-service bits, resolver sets winner
// - read command picks request or in-service view
// - mask bits block lines, data port reads mask
// - after initialization level 0 highest, 7 lowest
// - active lines set request bits, raise interrupt
// - first acknowledge resolves, sets in-service, no data
// - acknowledge with no request answers level seven
// - second acknowledge presents the vector
// - in-service bit blocks same and lower levels
// - nonspecific end clears highest in-service bit
// - special mask: nonspecific end skips masked bits
// - fully nested special: master takes cascade again
// - rotate on nonspecific end makes served level lowest
// - named level becomes lowest, others follow cyclically
// - special mask mode blocks each masked channel alone
// - read after poll acts as an acknowledge
// - poll byte: present flag bit7, level bits 2..0
// - command write with bit4 starts four-byte setup
// - setup clears mask, special mask, selects request view

module clic_top (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic [15:0] irq_in,
   input wire logic inta,
   output logic cpu_int,
   output logic [7:0] vec_data,
   output logic vec_valid
);

   // -------------------------------------------------------------
   // request inputs
   // -------------------------------------------------------------
   logic [15:0] irq_s;  // request pins after synchronising

   clic_sync #(
      .WIDTH(16)
   ) u_sync (
      .mclk(mclk),
      .resetn(resetn),
      .d(irq_in),
      .q(irq_s)
   );

   // -------------------------------------------------------------
   // per-controller state, index 0 master, 1 slave
   // -------------------------------------------------------------
   logic [7:0] mask_q [2];     // mask register
   logic [7:0] isr_q [2];      // in-service register
   logic [2:0] low_q [2];      // level with lowest priority
   logic smm_q [2];            // special mask mode
   logic sfnm_q [2];           // special fully nested mode
   logic rd_isr_q [2];         // command port shows in-service
   logic poll_q [2];           // next read is an acknowledge
   logic [4:0] base_q [2];     // vector bits 7..3
   clic_pkg::clic_init_e init_q [2]; // setup progress

   // combinational per-controller results
   logic [7:0] irr [2];        // request register, follows lines
   logic intr [2];             // controller wants service
   logic [2:0] win [2];        // level that would be served
   logic [7:0] set_ack [2];    // in-service bits set this cycle
   logic [7:0] rmux [2];       // read value of this controller
   logic hit [2];              // address falls on this controller

   // shared acknowledge bookkeeping
   logic ack_phase_q;          // 1 after the first pulse
   logic [7:0] vec_hold_q;     // vector waiting for second pulse
   logic ack_first;            // first pulse seen now
   logic ack_second;           // second pulse seen now
   logic via_slave;            // master winner is the cascade

   // level 2 of the master is the slave's output, and the old
   // level-2 pin is redirected onto slave input 1
   assign irr[0] = {irq_s[7:3], intr[1], irq_s[1:0]};
   assign irr[1] = irq_s[15:8]
                   | (8'(irq_s[2]) << clic_pkg::REDIR_BIT);

   assign ack_first = inta && !ack_phase_q;
   assign ack_second = inta && ack_phase_q;
   assign via_slave = intr[0] && (win[0] == clic_pkg::CASC_LVL);

   // -------------------------------------------------------------
   // the two controllers
   // -------------------------------------------------------------
   for (genvar c = 0; c < 2; c++) begin : g_ctl
      // address of this controller's two ports
      localparam logic [15:0] CMD_A =
         (c == 0) ? clic_pkg::M_CMD_OFS : clic_pkg::S_CMD_OFS;
      localparam logic [15:0] DATA_A =
         (c == 0) ? clic_pkg::M_DATA_OFS : clic_pkg::S_DATA_OFS;

      clic_res_if pend_if ();  // pending requests
      clic_res_if srv_if ();   // in-service bits

      clic_resolver u_pend (
         .bus(pend_if)
      );

      clic_resolver u_srv (
         .bus(srv_if)
      );

      // decode
      wire sel_cmd = (addr == CMD_A);
      wire sel_data = (addr == DATA_A);
      wire wr_cmd = wr && sel_cmd;
      wire wr_data = wr && sel_data;
      wire rd_hit = rd && (sel_cmd || sel_data);
      wire init1 = wr_cmd && wdata[clic_pkg::INIT1_BIT];
      wire opsel = wdata[clic_pkg::OPSEL_BIT];
      wire ocw2 = wr_cmd && !wdata[clic_pkg::INIT1_BIT] && !opsel;
      wire ocw3 = wr_cmd && !wdata[clic_pkg::INIT1_BIT] && opsel;
      wire [2:0] code = wdata[7:5];
      wire [2:0] op_lvl = wdata[2:0];
      wire [1:0] smm_f = wdata[clic_pkg::SMM_HI:clic_pkg::SMM_LO];
      wire [1:0] rr_f = wdata[clic_pkg::RR_HI:clic_pkg::RR_LO];

      // in special mask mode a masked in-service bit neither blocks
      // nor is chosen by a nonspecific end
      wire [7:0] eff_isr = smm_q[c] ? (isr_q[c] & ~mask_q[c])
                                    : isr_q[c];

      assign pend_if.req = irr[c] & ~mask_q[c];
      assign pend_if.low = low_q[c];
      assign srv_if.req = eff_isr;
      assign srv_if.low = low_q[c];

      // rank 0 is the highest priority under the current rotation
      wire [2:0] prank = 3'(pend_if.level - low_q[c] - 3'h1);
      wire [2:0] srank = 3'(srv_if.level - low_q[c] - 3'h1);
      // master re-accepts its cascade input while it is in service
      wire nest_ok = (c == 0) && sfnm_q[c] && (prank == srank)
                     && (pend_if.level == clic_pkg::CASC_LVL);

      assign intr[c] = pend_if.found
                       && (!srv_if.found || (prank < srank)
                           || nest_ok);
      assign win[c] = pend_if.level;

      // end-of-service decode
      wire eos_ns = ocw2 && srv_if.found
                    && (code == clic_pkg::EOS_NS
                        || code == clic_pkg::EOS_ROT_NS);
      wire eos_sp = ocw2 && (code == clic_pkg::EOS_SP
                             || code == clic_pkg::EOS_ROT_SP);
      wire rot_ns = eos_ns && (code == clic_pkg::EOS_ROT_NS);
      wire rot_sp = ocw2 && (code == clic_pkg::SET_PRIO
                             || code == clic_pkg::EOS_ROT_SP);
      wire [7:0] clr = eos_ns ? (8'h01 << srv_if.level)
                     : eos_sp ? (8'h01 << op_lvl) : 8'h00;

      // acknowledge or poll read takes the winner into service
      wire poll_rd = rd_hit && poll_q[c];
      wire take = (c == 0) ? (ack_first || poll_rd)
                           : ((ack_first && via_slave) || poll_rd);
      assign set_ack[c] = (take && intr[c]) ? (8'h01 << pend_if.level)
                                            : 8'h00;

      // read data: poll byte, request or in-service, else mask
      assign hit[c] = sel_cmd || sel_data;
      assign rmux[c] = poll_q[c]
                       ? {intr[c], 4'h0, pend_if.level}
                       : sel_cmd ? (rd_isr_q[c] ? isr_q[c]
                                                : irr[c])
                       : mask_q[c];

      // -----------------------------------------------------------
      // setup sequence and mode registers
      // -----------------------------------------------------------
      // a first setup byte always restarts the sequence
      always_ff @(posedge mclk or negedge resetn) begin
         if (!resetn) begin
            mask_q[c] <= clic_pkg::MASK_RST;
            smm_q[c] <= 1'b0;
            sfnm_q[c] <= 1'b0;
            rd_isr_q[c] <= 1'b0;
            base_q[c] <= 5'h00;
            init_q[c] <= clic_pkg::CLIC_READY;
         end else if (init1) begin
            // the level/edge bit is ignored: lines stay level
            mask_q[c] <= 8'h00;
            smm_q[c] <= 1'b0;
            sfnm_q[c] <= 1'b0;
            rd_isr_q[c] <= 1'b0;
            init_q[c] <= clic_pkg::CLIC_WANT2;
         end else if (wr_data) begin
            case (init_q[c])
               clic_pkg::CLIC_WANT2: begin
                  base_q[c] <= wdata[7:clic_pkg::VEC_LO];
                  init_q[c] <= clic_pkg::CLIC_WANT3;
               end
               clic_pkg::CLIC_WANT3: begin
                  // cascade identity is fixed by wiring here
                  init_q[c] <= clic_pkg::CLIC_WANT4;
               end
               clic_pkg::CLIC_WANT4: begin
                  sfnm_q[c] <= wdata[clic_pkg::SFNM_BIT];
                  init_q[c] <= clic_pkg::CLIC_READY;
               end
               default: begin
                  mask_q[c] <= wdata;
               end
            endcase
         end else if (ocw3) begin
            // codes 00 and 01 leave each selection unchanged
            if (smm_f[1]) begin
               smm_q[c] <= smm_f[0];
            end
            if (rr_f[1]) begin
               rd_isr_q[c] <= rr_f[0];
            end
         end
      end

      // -----------------------------------------------------------
      // in-service, rotation and poll
      // -----------------------------------------------------------
      // a set in the same cycle as a clear wins
      always_ff @(posedge mclk or negedge resetn) begin
         if (!resetn) begin
            isr_q[c] <= 8'h00;
            low_q[c] <= clic_pkg::LOW_RST;
            poll_q[c] <= 1'b0;
         end else begin
            isr_q[c] <= (isr_q[c] & ~clr) | set_ack[c];
            if (init1) begin
               low_q[c] <= clic_pkg::LOW_RST;
            end else if (rot_ns) begin
               low_q[c] <= srv_if.level;
            end else if (rot_sp) begin
               low_q[c] <= op_lvl;
            end
            if (init1) begin
               poll_q[c] <= 1'b0;
            end else if (ocw3) begin
               poll_q[c] <= wdata[clic_pkg::POLL_BIT];
            end else if (poll_rd) begin
               poll_q[c] <= 1'b0;
            end
         end
      end
   end

   // -------------------------------------------------------------
   // acknowledge handshake
   // -------------------------------------------------------------
   // the vector is fixed at the first pulse so a request that
   // drops between the pulses cannot change the answer
   wire [2:0] slv_lvl = intr[1] ? win[1] : clic_pkg::SPUR_LVL;
   wire [7:0] vec_now = !intr[0]
                        ? {base_q[0], clic_pkg::SPUR_LVL}
                        : via_slave ? {base_q[1], slv_lvl}
                        : {base_q[0], win[0]};

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ack_phase_q <= 1'b0;
         vec_hold_q <= 8'h00;
      end else if (ack_first) begin
         ack_phase_q <= 1'b1;
         vec_hold_q <= vec_now;
      end else if (ack_second) begin
         ack_phase_q <= 1'b0;
      end
   end

   // vec_valid strobes one cycle after the second pulse; vec_data holds the vector
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         vec_data <= 8'h00;
         vec_valid <= 1'b0;
      end else begin
         vec_valid <= ack_second;
         if (ack_second) begin
            vec_data <= vec_hold_q;
         end
      end
   end

   // -------------------------------------------------------------
   // interrupt output and read data
   // -------------------------------------------------------------
   wire [7:0] rd_sel = hit[0] ? rmux[0]
                     : hit[1] ? rmux[1] : 8'h00;

   // unmapped reads return zero; data stands one cycle only
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rdata <= 8'h00;
         cpu_int <= 1'b0;
      end else begin
         rdata <= rd ? rd_sel : 8'h00;
         cpu_int <= intr[0];
      end
   end

endmodule

`default_nettype wire

// *** clic_top_chk.sv ***
// assertion checker bound to the controller pair top
`default_nettype none

module clic_top_chk (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic [15:0] irq_in,
   input wire logic inta,
   input wire logic cpu_int,
   input wire logic [7:0] vec_data,
   input wire logic vec_valid
);
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------
   // helper state
   // ------------------------------------------
   logic phase_q; // high between first and second acknowledge
   logic poll_q;  // poll written, its read not yet seen
   wire logic cmd_wr = wr && (addr == clic_pkg::M_CMD_OFS
      || addr == clic_pkg::S_CMD_OFS);
   wire logic mapped = addr == clic_pkg::M_CMD_OFS
      || addr == clic_pkg::M_DATA_OFS || addr == clic_pkg::S_CMD_OFS
      || addr == clic_pkg::S_DATA_OFS;

   // pulses alternate; a poll lives until the next read
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         phase_q <= 1'b0;
         poll_q <= 1'b0;
      end else begin
         if (inta) begin
            phase_q <= !phase_q;
         end
         if (cmd_wr) begin
            poll_q <= (wdata[4:2] == 3'b011);
         end else if (rd) begin
            poll_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------
   // properties
   // ------------------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);

   a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data not zero outside a read answer");
   a_unmapped_zero: assert property (rd && !mapped |=> rdata == 8'h00)
      else $error("unmapped read returned data");
   // five quiet samples cover two sync stages and the output flop
   a_level_quiet: assert property ((irq_in == 16'h0000)[*5] |-> !cpu_int)
      else $error("interrupt held with no request line high");
   a_int_cause: assert property ($rose(cpu_int) |-> $past(irq_in, 3) != 0)
      else $error("interrupt raised without a request");
   a_first_silent: assert property (inta && !phase_q |=> !vec_valid)
      else $error("vector presented after first acknowledge");
   a_vec_cause: assert property (vec_valid |-> $past(inta) && $past(phase_q))
      else $error("vector not caused by second acknowledge");
   a_vec_single: assert property (vec_valid |=> !vec_valid)
      else $error("vector strobe longer than one cycle");
   a_vec_hold: assert property (!vec_valid |-> $stable(vec_data))
      else $error("vector changed without strobe");
   a_spur_seven: assert property ((irq_in == 16'h0000)[*5] ##0
      (inta && !phase_q) ##1 inta |=> vec_valid && vec_data[2:0] == 3'h7)
      else $error("empty acknowledge did not answer level seven");
   a_poll_form: assert property (poll_q && rd |=> rdata[6:3] == 4'h0)
      else $error("poll byte middle bits not clear");

   c_vector: cover property (vec_valid && vec_data[2:0] != 3'h7);
   c_poll: cover property (poll_q && rd);
   c_int: cover property ($rose(cpu_int));
endmodule

bind clic_top clic_top_chk clic_top_chk_inst (
   .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata(rdata), .irq_in(irq_in), .inta(inta),
   .cpu_int(cpu_int), .vec_data(vec_data), .vec_valid(vec_valid)
);

`default_nettype wire

// *** test_clic_top.sv ***
// self-checking bench for the cascaded controller pair
`default_nettype none

module test_clic_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, resetn, wr, rd, inta, cpu_int, vec_valid, rd_d;
   logic [15:0] addr, irq_in;
   logic [7:0] wdata, rdata, vec_data, bm, bs;
   logic [7:0] exp_q[$]; // results yet to appear, oldest first
   logic [31:0] lfsr;    // random source
   int n_errors;
   int check_count;

   clic_top clic_top_inst (.mclk(mclk), .resetn(resetn), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq_in(irq_in),
      .inta(inta), .cpu_int(cpu_int), .vec_data(vec_data),
      .vec_valid(vec_valid));
   clic_host clic_host_inst (.mclk(mclk), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .inta(inta));

   // 40 ns clock
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // ------------------------------------------
   // helpers
   // ------------------------------------------
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] want);
      check_count++;
      if (got !== want) begin
         n_errors++;
         $display("BAD t=%0t got=%h want=%h", $time, got, want);
      end
   endtask

   task automatic w(input logic [15:0] a, input logic [7:0] d);
      clic_host_inst.put(a, d);
   endtask

   task automatic rdx(input logic [15:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      clic_host_inst.get(a);
   endtask

   task automatic ackx(input logic [7:0] e);
      exp_q.push_back(e);
      clic_host_inst.ack();
   endtask

   // pin to interrupt takes three edges; five leaves margin
   task automatic lvl(input logic e);
      repeat (5) @(posedge mclk);
      chk({7'h00, cpu_int}, {7'h00, e});
   endtask

   // four-byte setup: marker, vector base, cascade byte, mode
   task automatic setup(input logic [15:0] c, input logic [7:0] b,
      input logic [7:0] cs);
      w(c, 8'h11);
      w(c + 16'h0001, b);
      w(c + 16'h0001, cs);
      w(c + 16'h0001, 8'h01);
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // each answer is matched against the oldest noted expectation
   always @(posedge mclk) begin
      if (rd_d === 1'b1) begin
         chk(rdata, exp_q.pop_front());
      end
      if (vec_valid === 1'b1) begin
         chk(vec_data, exp_q.pop_front());
      end
      rd_d <= rd;
   end

   // hang guard
   initial begin
      #100000;
      n_errors++;
      results();
   end

   // ------------------------------------------
   // scenarios
   // ------------------------------------------
   initial begin
      resetn = 1'b0;
      irq_in = 16'h0000;
      rd_d = 1'b0;
      n_errors = 0;
      check_count = 0;
      lfsr = nxt(32'hb78c7da5);
      bm = lfsr[7:0] & 8'hF8;
      bs = lfsr[15:8] & 8'hF8;
      repeat (20) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      rdx(16'h0021, 8'hFF);
      setup(16'h0020, bm, 8'h04);
      setup(16'h00A0, bs, 8'h02);
      rdx(16'h0021, 8'h00);
      rdx(16'h00A1, 8'h00);
      rdx(16'h0020, 8'h00);
      lfsr = nxt(lfsr);
      w(16'h0021, lfsr[7:0]);
      rdx(16'h0021, lfsr[7:0]);
      w(16'h0021, 8'h00);
      $display("setup done");
      irq_in <= 16'h0008;
      lvl(1'b1);
      ackx(bm | 8'h03);
      w(16'h0020, 8'h0B);
      rdx(16'h0020, 8'h08);
      rdx(16'h0020, 8'h08);
      irq_in <= 16'h000A;
      lvl(1'b1);
      ackx(bm | 8'h01);
      irq_in <= 16'h002A;
      lvl(1'b0);
      irq_in <= 16'h0008;
      w(16'h0020, 8'h20);
      rdx(16'h0020, 8'h08);
      w(16'h0020, 8'h20);
      lvl(1'b1);
      ackx(bm | 8'h03);
      irq_in <= 16'h0000;
      w(16'h0020, 8'h20);
      rdx(16'h0020, 8'h00);
      $display("nesting done");
      irq_in <= 16'h1000;
      lvl(1'b1);
      ackx(bs | 8'h04);
      rdx(16'h0020, 8'h04);
      w(16'h00A0, 8'h0B);
      rdx(16'h00A0, 8'h10);
      irq_in <= 16'h0000;
      w(16'h00A0, 8'h20);
      rdx(16'h00A0, 8'h00);
      w(16'h0020, 8'h20);
      rdx(16'h0020, 8'h00);
      ackx(bm | 8'h07);
      rdx(16'h0020, 8'h00);
      $display("cascade done");
      w(16'h0021, 8'h01);
      irq_in <= 16'h0011;
      lvl(1'b1);
      ackx(bm | 8'h04);
      irq_in <= 16'h0000;
      w(16'h0020, 8'h20);
      w(16'h0021, 8'h00);
      w(16'h0020, 8'hC5);
      irq_in <= 16'h0050;
      lvl(1'b1);
      ackx(bm | 8'h06);
      irq_in <= 16'h0000;
      w(16'h0020, 8'h66);
      rdx(16'h0020, 8'h00);
      irq_in <= 16'h0011;
      lvl(1'b1);
      ackx(bm | 8'h00);
      w(16'h0020, 8'hA0);
      w(16'h0020, 8'h0C);
      rdx(16'h0020, 8'h84);
      w(16'h0020, 8'hE4);
      w(16'h0020, 8'h0C);
      rdx(16'h0020, 8'h80);
      rdx(16'h0020, 8'h01);
      irq_in <= 16'h0000;
      w(16'h0020, 8'h20);
      w(16'h0020, 8'hC7);
      $display("rotation done");
      irq_in <= 16'h0081;
      lvl(1'b1);
      ackx(bm | 8'h00);
      w(16'h0020, 8'h68);
      w(16'h0021, 8'h01);
      irq_in <= 16'h0008;
      lvl(1'b1);
      ackx(bm | 8'h03);
      irq_in <= 16'h0000;
      w(16'h0020, 8'h20);
      rdx(16'h0020, 8'h01);
      w(16'h0020, 8'h48);
      w(16'h0021, 8'h00);
      w(16'h0020, 8'h20);
      rdx(16'h0020, 8'h00);
      $display("special mask done");
      w(16'h0020, 8'h11);
      w(16'h0021, bm);
      w(16'h0021, 8'h04);
      w(16'h0021, 8'h11);
      irq_in <= 16'h1000;
      lvl(1'b1);
      ackx(bs | 8'h04);
      irq_in <= 16'h1100;
      lvl(1'b1);
      ackx(bs | 8'h00);
      irq_in <= 16'h0000;
      w(16'h00A0, 8'h20);
      rdx(16'h00A0, 8'h10);
      w(16'h00A0, 8'h20);
      rdx(16'h00A0, 8'h00);
      w(16'h0020, 8'h20);
      w(16'h0020, 8'h0B);
      rdx(16'h0020, 8'h00);
      $display("special nesting done");
      results();
   end
endmodule

`default_nettype wire
